// >>> logic/i2csl_defines.svh
/*
  Constants of the two-wire slave and bit-banged master block: register
  offsets, control field positions, reset values and filter timing.
  Assumes it is included by bare name from the design; the package does not include it.
*/
// Contract
// - Master-select bit set gives software master mode; cleared gives hardware slave.
// - Master mode with drive enable set drives data pin to data-out bit.
// - Master mode always drives the clock pin from the clock-out bit.
// - Master mode, drive enable clear: data released, sampled on rising clock.
// - After reset the interface is in hardware slave mode.
// - Interface needs SPI enable clear; slave also needs master-select clear.
// - Slave answers either of two 7-bit addresses in writable registers.
// - Start, matching address and direction bit set the byte-done flag.
// - Interrupt request needs byte-done, peripheral enable and global enable.
// - Any data register access clears byte-done and the pending interrupt.
// - One data access per byte event; a second halts slave until reset bit.
// - Interrupt is raised at the end of each acknowledged byte.
// - First byte shows received 7-bit address with direction bit.
// - Direction flag holds master's read/write bit; set means slave transmits.
// - Addressed slave holds clock low until byte-done is cleared.
// - Byte-done set only for bytes followed by ACK; NACK gives no event.
// - Byte events continue for every ACKed byte until stop, NACK or interface reset.
// - Stop or NACK returns the slave to idle, waiting for its address.
// - Interface reset bit forces the slave state machine to idle.
// - Glitch filter rejects short spikes on data and clock lines.
// - Address registers writable; reset values 55h and 7fh.
// - Interface reset bit holds slave in reset until software clears it.
`ifndef I2CSL_DEFINES_SVH
`define I2CSL_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets and reset values
// ----------------------------------------------------------------
`define I2CSL_OFS_DATA 8'h9a
`define I2CSL_OFS_ADDR_PRI 8'h9b
`define I2CSL_OFS_ADDR_SEC 8'hf2
`define I2CSL_OFS_CTRL 8'he8
`define I2CSL_RST_DATA 8'h00
`define I2CSL_RST_ADDR_PRI 8'h55
`define I2CSL_RST_ADDR_SEC 8'h7f

// ----------------------------------------------------------------
// Control register bit positions
// ----------------------------------------------------------------
`define I2CSL_B_DOUT 7
`define I2CSL_B_DEN 6
`define I2CSL_B_COUT 5
`define I2CSL_B_DIN 4
`define I2CSL_B_MSEL 3
`define I2CSL_B_IRS 2
`define I2CSL_B_DIR 1
`define I2CSL_B_DONE 0

// ----------------------------------------------------------------
// Glitch filter timing (link clock cycles, least time rounds up)
// ----------------------------------------------------------------
`define I2CSL_GLITCH_NS 50
`define I2CSL_LINK_CLK_NS 30
`define I2CSL_FILT_CYC ((`I2CSL_GLITCH_NS + `I2CSL_LINK_CLK_NS - 1) / `I2CSL_LINK_CLK_NS)

`endif

// >>> logic/i2csl_pkg.sv
/*
  Types of the two-wire slave block: link state enum and the two state
  structs, one per clock domain. Assumes nothing beyond the defines header.
*/
package i2csl_pkg;
  // ----------------------------------------------------------------
  // Slave engine states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    I2CSL_IDLE = 3'b000,
    I2CSL_ADDR = 3'b001,
    I2CSL_RX = 3'b010,
    I2CSL_TX = 3'b011,
    I2CSL_ACK_OUT = 3'b100,
    I2CSL_ACK_IN = 3'b101,
    I2CSL_HOLD = 3'b110
  } i2csl_state_e;

  typedef logic [1:0] i2csl_cnt_t;

  // Link domain state
  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic scl_s1;
    logic scl_s2;
    logic sda_s1;
    logic sda_s2;
    logic scl_f;
    logic sda_f;
    i2csl_cnt_t scl_cnt;
    i2csl_cnt_t sda_cnt;
    logic [4:0] ctl_s1;
    logic [4:0] ctl_s2;
    logic rel_s1;
    logic rel_s2;
    logic rel_prev;
    logic [7:0] ap_s1;
    logic [7:0] ap_s2;
    logic [7:0] as_s1;
    logic [7:0] as_s2;
    i2csl_state_e state;
    logic [7:0] shift;
    logic [3:0] cnt;
    logic dir;
    logic ack;
    logic evt_tgl;
    logic [7:0] rx_byte;
    logic din;
    logic sda_drv;
    logic sda_out;
    logic sda_oe;
    logic scl_out;
    logic scl_oe;
  } i2csl_link_s;

  // Core domain state
  typedef struct packed {
    logic dout;
    logic den;
    logic cout;
    logic msel;
    logic irs;
    logic done;
    logic dir;
    logic accessed;
    logic stopped;
    logic rel_tgl;
    logic [7:0] data;
    logic [7:0] addr_pri;
    logic [7:0] addr_sec;
    logic evt_s1;
    logic evt_s2;
    logic evt_prev;
    logic din_s1;
    logic din_s2;
    logic [7:0] rdata;
    logic irq;
  } i2csl_core_s;
endpackage : i2csl_pkg

// >>> logic/i2csl_top.sv
/*
  Two-wire serial interface: hardware slave with clock stretching plus a
  software bit-banged master, registers on the core SFR bus.
  Assumes pins are open-drain pads resolved outside, link_clk free running
  as the pad sampling clock, and spi/interrupt enables from the core.
*/
`timescale 1ns/10ps
`include "i2csl_defines.svh"

module i2csl_top
  import i2csl_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic link_clk,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic spi_enable_bit,
  input wire logic periph_int_enable,
  input wire logic global_int_enable_bit,
  output logic int_req,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);

  localparam i2csl_cnt_t FILT = i2csl_cnt_t'(`I2CSL_FILT_CYC);

  i2csl_core_s rc;
  i2csl_core_s nc;
  i2csl_link_s rl;
  i2csl_link_s nl;

  // ----------------------------------------------------------------
  // Core domain: SFR registers, byte-done flag, interrupt
  // ----------------------------------------------------------------

  // Register writes, data access handling and event arrival
  always_comb begin
    logic dat_acc;
    logic evt_new;
    dat_acc = 1'b0;
    evt_new = 1'b0;
    nc = rc;
    nc.evt_s1 = rl.evt_tgl;
    nc.evt_s2 = rc.evt_s1;
    nc.evt_prev = rc.evt_s2;
    nc.din_s1 = rl.din;
    nc.din_s2 = rc.din_s1;
    dat_acc = (sfr_wr || sfr_rd) && (sfr_addr == `I2CSL_OFS_DATA);
    evt_new = rc.evt_s2 ^ rc.evt_prev;
    if (sfr_wr) begin
      case (sfr_addr)
        `I2CSL_OFS_DATA: nc.data = sfr_wdata;
        `I2CSL_OFS_ADDR_PRI: nc.addr_pri = sfr_wdata;
        `I2CSL_OFS_ADDR_SEC: nc.addr_sec = sfr_wdata;
        `I2CSL_OFS_CTRL: begin
          nc.dout = sfr_wdata[`I2CSL_B_DOUT];
          nc.den = sfr_wdata[`I2CSL_B_DEN];
          nc.cout = sfr_wdata[`I2CSL_B_COUT];
          nc.msel = sfr_wdata[`I2CSL_B_MSEL];
          nc.irs = sfr_wdata[`I2CSL_B_IRS];
        end
        default: nc.msel = rc.msel;
      endcase
    end
    // Only the first access per event releases the link
    if (dat_acc) begin
      nc.done = 1'b0;
      if (rc.accessed) begin
        nc.stopped = 1'b1;
      end else begin
        nc.accessed = 1'b1;
        if (rc.done && !rc.stopped) begin
          nc.rel_tgl = ~rc.rel_tgl;
        end
      end
    end
    // Event set wins over a same-cycle access clear
    if (evt_new) begin
      nc.done = 1'b1;
      nc.accessed = 1'b0;
      if (!dat_acc || sfr_rd) begin
        nc.data = rl.rx_byte;
      end
      nc.dir = rl.dir;
    end
    // Interface reset clears the halt and leaves the engine idle
    if (rc.irs) begin
      nc.stopped = 1'b0;
      nc.accessed = 1'b0;
      nc.done = 1'b0;
    end
    // Read mux is registered; unmapped offsets read zero
    if (sfr_rd) begin
      case (sfr_addr)
        `I2CSL_OFS_DATA: nc.rdata = rc.data;
        `I2CSL_OFS_ADDR_PRI: nc.rdata = rc.addr_pri;
        `I2CSL_OFS_ADDR_SEC: nc.rdata = rc.addr_sec;
        `I2CSL_OFS_CTRL: nc.rdata = {rc.dout, rc.den, rc.cout, rc.din_s2,
                                     rc.msel, rc.irs, rc.dir, rc.done};
        default: nc.rdata = 8'h00;
      endcase
    end
    nc.irq = nc.done && periph_int_enable && global_int_enable_bit;
    if (!nrst) begin
      nc = '0;
      nc.msel = 1'b0;
      nc.data = `I2CSL_RST_DATA;
      nc.addr_pri = `I2CSL_RST_ADDR_PRI;
      nc.addr_sec = `I2CSL_RST_ADDR_SEC;
    end
  end

  // Core state register
  always_ff @(posedge clk) begin
    rc <= nc;
  end

  // ----------------------------------------------------------------
  // Link domain: pad sync, glitch filter, slave engine, pin drivers
  // ----------------------------------------------------------------

  // Slave engine and master pass-through on filtered pads
  always_comb begin
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic run;
    logic mst;
    logic rel_new;
    rise = 1'b0;
    fall = 1'b0;
    start = 1'b0;
    stop = 1'b0;
    run = 1'b0;
    mst = 1'b0;
    rel_new = 1'b0;
    nl = rl;
    nl.rst_s1 = nrst;
    nl.rst_s2 = rl.rst_s1;
    nl.scl_s1 = scl_in;
    nl.scl_s2 = rl.scl_s1;
    nl.sda_s1 = sda_in;
    nl.sda_s2 = rl.sda_s1;
    // Control levels cross by two flops; they change only between frames
    // SPI enable is folded in before the sync so the link never reads it raw
    nl.ctl_s1 = {rc.msel & ~spi_enable_bit, rc.den, rc.dout, rc.cout,
                 ~spi_enable_bit & ~rc.msel & ~rc.irs & ~rc.stopped};
    nl.ctl_s2 = rl.ctl_s1;
    nl.ap_s1 = rc.addr_pri;
    nl.ap_s2 = rl.ap_s1;
    nl.as_s1 = rc.addr_sec;
    nl.as_s2 = rl.as_s1;
    nl.rel_s1 = rc.rel_tgl;
    nl.rel_s2 = rl.rel_s1;
    nl.rel_prev = rl.rel_s2;
    // Accept a new level only after it held for the filter time
    if (rl.scl_s2 == rl.scl_f) begin
      nl.scl_cnt = '0;
    end else if (rl.scl_cnt == FILT - i2csl_cnt_t'(1)) begin
      nl.scl_f = rl.scl_s2;
      nl.scl_cnt = '0;
    end else begin
      nl.scl_cnt = rl.scl_cnt + i2csl_cnt_t'(1);
    end
    if (rl.sda_s2 == rl.sda_f) begin
      nl.sda_cnt = '0;
    end else if (rl.sda_cnt == FILT - i2csl_cnt_t'(1)) begin
      nl.sda_f = rl.sda_s2;
      nl.sda_cnt = '0;
    end else begin
      nl.sda_cnt = rl.sda_cnt + i2csl_cnt_t'(1);
    end
    rise = nl.scl_f && !rl.scl_f;
    fall = !nl.scl_f && rl.scl_f;
    start = rl.scl_f && nl.scl_f && rl.sda_f && !nl.sda_f;
    stop = rl.scl_f && nl.scl_f && !rl.sda_f && nl.sda_f;
    run = rl.ctl_s2[0];
    mst = rl.ctl_s2[4];
    rel_new = rl.rel_s2 ^ rl.rel_prev;
    // Master data-in latches on rising clock with the driver off
    if (mst && rise && !rl.ctl_s2[3]) begin
      nl.din = nl.sda_f;
    end
    // Slave byte engine
    if (!run) begin
      nl.state = I2CSL_IDLE;
      nl.sda_drv = 1'b0;
    end else if (stop) begin
      nl.state = I2CSL_IDLE;
      nl.sda_drv = 1'b0;
    end else if (start) begin
      nl.state = I2CSL_ADDR;
      nl.cnt = 4'h0;
      nl.sda_drv = 1'b0;
    end else begin
      case (rl.state)
        I2CSL_IDLE: nl.sda_drv = 1'b0;
        I2CSL_ADDR, I2CSL_RX: begin
          if (rise) begin
            nl.shift = {rl.shift[6:0], nl.sda_f};
            nl.cnt = rl.cnt + 4'h1;
          end else if (fall && rl.cnt == 4'h8) begin
            if (rl.state == I2CSL_RX) begin
              nl.sda_drv = 1'b1;
              nl.state = I2CSL_ACK_OUT;
            end else if (rl.shift[7:1] == rl.ap_s2[6:0]
                         || rl.shift[7:1] == rl.as_s2[6:0]) begin
              nl.dir = rl.shift[0];
              nl.sda_drv = 1'b1;
              nl.state = I2CSL_ACK_OUT;
            end else begin
              nl.state = I2CSL_IDLE;
            end
          end
        end
        I2CSL_ACK_OUT: begin
          // Byte complete: post event, stretch the clock
          if (fall) begin
            nl.sda_drv = 1'b0;
            nl.rx_byte = rl.shift;
            nl.evt_tgl = ~rl.evt_tgl;
            nl.state = I2CSL_HOLD;
          end
        end
        I2CSL_HOLD: begin
          // Released by the first data access in the core
          if (rel_new) begin
            nl.cnt = 4'h0;
            if (rl.dir) begin
              nl.shift = rc.data;
              nl.sda_drv = ~rc.data[7];
              nl.state = I2CSL_TX;
            end else begin
              nl.state = I2CSL_RX;
            end
          end
        end
        I2CSL_TX: begin
          if (rise) begin
            nl.cnt = rl.cnt + 4'h1;
          end else if (fall) begin
            if (rl.cnt == 4'h8) begin
              nl.sda_drv = 1'b0;
              nl.state = I2CSL_ACK_IN;
            end else begin
              nl.shift = {rl.shift[6:0], 1'b0};
              nl.sda_drv = ~rl.shift[6];
            end
          end
        end
        I2CSL_ACK_IN: begin
          if (rise) begin
            nl.ack = !nl.sda_f;
          end else if (fall) begin
            if (rl.ack) begin
              nl.evt_tgl = ~rl.evt_tgl;
              nl.state = I2CSL_HOLD;
            end else begin
              nl.state = I2CSL_IDLE;
            end
          end
        end
        default: nl.state = I2CSL_IDLE;
      endcase
    end
    // Pin drivers: push-pull in master mode, open-drain in slave mode
    if (mst) begin
      nl.scl_out = rl.ctl_s2[1];
      nl.scl_oe = 1'b1;
      nl.sda_out = rl.ctl_s2[2];
      nl.sda_oe = rl.ctl_s2[3];
    end else begin
      nl.scl_out = 1'b0;
      nl.scl_oe = run && (nl.state == I2CSL_HOLD);
      nl.sda_out = 1'b0;
      nl.sda_oe = run && nl.sda_drv;
    end
    // Held reset: keep the reset synchroniser and pad first stages running, track the release toggle
    if (!rl.rst_s2) begin
      nl = '0;
      nl.rst_s1 = nrst;
      nl.rst_s2 = rl.rst_s1;
      nl.scl_f = 1'b1;
      nl.sda_f = 1'b1;
      nl.scl_s1 = scl_in;
      nl.sda_s1 = sda_in;
      nl.rel_s1 = rc.rel_tgl;
      nl.rel_s2 = rc.rel_tgl;
      nl.rel_prev = rc.rel_tgl;
      nl.state = I2CSL_IDLE;
    end
  end

  // Link state register
  always_ff @(posedge link_clk) begin
    rl <= nl;
  end

  // ----------------------------------------------------------------
  // Outputs straight from flops
  // ----------------------------------------------------------------
  assign sfr_rdata = rc.rdata;
  assign int_req = rc.irq;
  assign scl_out = rl.scl_out;
  assign scl_oe = rl.scl_oe;
  assign sda_out = rl.sda_out;
  assign sda_oe = rl.sda_oe;

endmodule : i2csl_top

// >>> sim/i2csl_checker.sv
/*
  Port checker of the two-wire block: register reads, interrupt gating, pins.
  Assumes it is bound to the top module and sees its ports only.
*/
`timescale 1ns/10ps
module i2csl_checker
  import i2csl_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic link_clk,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic spi_enable_bit,
  input wire logic periph_int_enable,
  input wire logic global_int_enable_bit,
  input wire logic int_req,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe
);
  // ------------------------------------------------------------
  // Shadows of the written registers
  // ------------------------------------------------------------
  logic [7:0] ctl_reg;
  logic [7:0] apri_reg;
  logic [3:0] cnt_reg;
  logic spi_reg;
  logic settled;
  // Pins lag control writes by sync stages, so wait until settled
  assign settled = cnt_reg == 4'hf;
  always_ff @(posedge clk) begin
    spi_reg <= spi_enable_bit;
    if (!nrst) begin
      ctl_reg <= 8'h00;
      apri_reg <= 8'h55;
      cnt_reg <= 4'h0;
    end else begin
      if (sfr_wr && sfr_addr == 8'he8) ctl_reg <= sfr_wdata;
      if (sfr_wr && sfr_addr == 8'h9b) apri_reg <= sfr_wdata;
      if ((sfr_wr && sfr_addr == 8'he8) || spi_reg != spi_enable_bit) cnt_reg <= 4'h0;
      else if (!settled) cnt_reg <= cnt_reg + 4'h1;
    end
  end
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  irq_gate_a: assert property (@(posedge clk) disable iff (!nrst)
    int_req |-> $past(periph_int_enable) && $past(global_int_enable_bit))
    else $error("interrupt without both enables");
  data_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    (sfr_rd || sfr_wr) && sfr_addr == 8'h9a |=> ##1 !int_req)
    else $error("interrupt kept after data access");
  addr_read_a: assert property (@(posedge clk) disable iff (!nrst)
    sfr_rd && sfr_addr == 8'h9b |=> sfr_rdata == $past(apri_reg))
    else $error("primary address read wrong");
  ctrl_read_a: assert property (@(posedge clk) disable iff (!nrst)
    sfr_rd && sfr_addr == 8'he8 |=> (sfr_rdata & 8'hec) == ($past(ctl_reg) & 8'hec))
    else $error("control read wrong");
  master_clk_a: assert property (@(posedge clk) disable iff (!nrst)
    settled && ctl_reg[3] && !spi_enable_bit |-> scl_oe && scl_out == ctl_reg[5])
    else $error("master clock pin wrong");
  master_data_a: assert property (@(posedge clk) disable iff (!nrst)
    settled && ctl_reg[3] && !spi_enable_bit |-> sda_oe == ctl_reg[6]
      && (!ctl_reg[6] || sda_out == ctl_reg[7]))
    else $error("master data pin wrong");
  spi_off_a: assert property (@(posedge clk) disable iff (!nrst)
    settled && spi_enable_bit |-> !scl_oe && !sda_oe)
    else $error("pins driven while disabled");
  irs_idle_a: assert property (@(posedge clk) disable iff (!nrst)
    settled && ctl_reg[2] && !ctl_reg[3] |-> !scl_oe && !sda_oe)
    else $error("pins driven in interface reset");
endmodule : i2csl_checker

bind i2csl_top i2csl_checker chk_u (.*);

// >>> sim/i2csl_ext_master.sv
/*
  External two-wire master model with open-drain pulls; waits out stretches.
  Assumes pull-ups on both wires, resolved by the bench.
*/
`timescale 1ns/10ps
module i2csl_ext_master #(
  parameter int HALF_NS = 500
) (
  input wire logic scl_w,
  input wire logic sda_w,
  output logic scl_low,
  output logic sda_low
);
  int stuck = 0;
  // Both wires released at start
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // Release the clock and wait out a stretch, bounded
  task automatic rise();
    int n;
    n = 0;
    scl_low = 1'b0;
    while (!scl_w && n < 500) begin
      #10;
      n++;
    end
    if (!scl_w) stuck++;
  endtask : rise
  // Data moves a while after the clock falls, never with it
  task automatic bit_io(input logic b, output logic s);
    sda_low = !b;
    #HALF_NS;
    rise();
    #HALF_NS;
    s = sda_w;
    scl_low = 1'b1;
    #100;
  endtask : bit_io
  // Eight bits MSB first, then the ninth bit
  task automatic byte_io(input logic [7:0] tx, input logic b9, output logic [7:0] rx,
    output logic s9);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], s);
      rx[i] = s;
    end
    bit_io(b9, s9);
  endtask : byte_io
  task automatic start();
    sda_low = 1'b1;
    #HALF_NS;
    scl_low = 1'b1;
    #100;
  endtask : start
  task automatic stop();
    sda_low = 1'b1;
    #HALF_NS;
    rise();
    #HALF_NS;
    sda_low = 1'b0;
    #HALF_NS;
  endtask : stop
endmodule : i2csl_ext_master

// >>> sim/i2csl_top_tb.sv
/*
  Bench of the two-wire block: registers, slave transfers, software master.
  Assumes the model and checker files are compiled before it.
*/
`timescale 1ns/10ps
module i2csl_top_tb;
  logic clk, nrst, link_clk, sfr_wr, sfr_rd, spi_enable_bit, int_req;
  logic periph_int_enable, global_int_enable_bit, scl_in, sda_in, ack, r;
  logic scl_out, scl_oe, sda_out, sda_oe, scl_low, sda_low;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rd, rx, b, sec;
  logic [7:0] ofs [4] = '{8'h9a, 8'h9b, 8'hf2, 8'he8};
  logic [7:0] rst [4] = '{8'h00, 8'h55, 8'h7f, 8'h00};
  int errors = 0;
  int check_count = 0;
  int seed = 32'ha998;
  // Pulled-up wires; the design drives push-pull only in master mode
  assign scl_in = (scl_oe ? scl_out : 1'b1) & !scl_low;
  assign sda_in = (sda_oe ? sda_out : 1'b1) & !sda_low;
  i2csl_top dut_u (.*);
  i2csl_ext_master pm_u (.scl_w(scl_in), .sda_w(sda_in), .scl_low(scl_low), .sda_low(sda_low));
  // Core and link clocks, unrelated in phase
  initial begin
    clk = 1'b0;
    forever #10 clk = !clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #15 link_clk = !link_clk;
  end
  // Hang guard
  initial begin
    #1000000;
    errors++;
    final_report();
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report
  // One-cycle strobe; read data lands one edge later
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    sfr_wr = w;
    sfr_rd = !w;
    sfr_addr = a;
    sfr_wdata = d;
    @(posedge clk);
    #1;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    rd = sfr_rdata;
  endtask : acc
  task automatic settle();
    repeat (10) @(posedge clk);
    #1;
  endtask : settle
  // Poll the byte-done flag within a bound
  task automatic wait_done();
    int n;
    n = 0;
    rd = 8'h00;
    while (!rd[0] && n < 200) begin
      acc(1'b0, 8'he8, 8'h00);
      n++;
    end
    check(rd[0], 1'b1);
    if (!rd[0]) final_report();
  endtask : wait_done
  task automatic addr(input logic [7:0] a, input logic exp);
    pm_u.start();
    pm_u.byte_io(a, 1'b1, rx, ack);
    check(ack, exp);
  endtask : addr
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    spi_enable_bit = 1'b0;
    periph_int_enable = 1'b1;
    global_int_enable_bit = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    nrst = 1'b1;
    foreach (ofs[k]) begin
      acc(1'b0, ofs[k], 8'h00);
      check(rd, rst[k]);
    end
    acc(1'b0, 8'h00, 8'h00);
    check(rd, 8'h00);
    sec = 8'h40 | (8'($random(seed)) & 8'h3f);
    if (sec == 8'h55) sec = 8'h56;
    acc(1'b1, 8'hf2, sec);
    acc(1'b0, 8'hf2, 8'h00);
    check(rd, sec);
    settle();
    // Write transfer: address byte, gated interrupt, random data byte
    addr({7'h55, 1'b0}, 1'b0);
    wait_done();
    check(rd[1], 1'b0);
    for (int k = 0; k < 4; k++) begin
      periph_int_enable = k[0];
      global_int_enable_bit = k[1];
      settle();
      check(int_req, k == 3);
    end
    acc(1'b0, 8'h9a, 8'h00);
    check(rd, {7'h55, 1'b0});
    check(int_req, 1'b0);
    b = 8'($random(seed));
    pm_u.byte_io(b, 1'b1, rx, ack);
    check(ack, 1'b0);
    wait_done();
    acc(1'b0, 8'h9a, 8'h00);
    check(rd, b);
    pm_u.stop();
    addr({7'h2a, 1'b0}, 1'b1);
    pm_u.stop();
    // Read transfer ended by a NACK gives no event
    addr({sec[6:0], 1'b1}, 1'b0);
    wait_done();
    check(rd[1], 1'b1);
    b = 8'($random(seed));
    acc(1'b1, 8'h9a, b);
    pm_u.byte_io(8'hff, 1'b1, rx, ack);
    check(rx, b);
    settle();
    acc(1'b0, 8'he8, 8'h00);
    check(rd[0], 1'b0);
    pm_u.stop();
    // Double access halts the slave until the reset bit cycles
    addr({7'h55, 1'b0}, 1'b0);
    wait_done();
    acc(1'b0, 8'h9a, 8'h00);
    acc(1'b0, 8'h9a, 8'h00);
    pm_u.stop();
    addr({7'h55, 1'b0}, 1'b1);
    pm_u.stop();
    acc(1'b1, 8'he8, 8'h04);
    settle();
    addr({7'h55, 1'b0}, 1'b1);
    pm_u.stop();
    acc(1'b1, 8'he8, 8'h00);
    settle();
    addr({7'h55, 1'b0}, 1'b0);
    wait_done();
    acc(1'b0, 8'h9a, 8'h00);
    pm_u.stop();
    spi_enable_bit = 1'b1;
    settle();
    addr({7'h55, 1'b0}, 1'b1);
    pm_u.stop();
    spi_enable_bit = 1'b0;
    // Software master: random pin levels, then data-in capture
    for (int k = 0; k < 6; k++) begin
      b = (8'($random(seed)) & 8'he0) | 8'h08;
      acc(1'b1, 8'he8, b);
      settle();
      check({scl_oe, scl_out}, {1'b1, b[5]});
      check({sda_oe, sda_oe & sda_out}, {b[6], b[6] & b[7]});
    end
    for (int k = 0; k < 4; k++) begin
      r = 1'($random(seed));
      pm_u.sda_low = !r;
      acc(1'b1, 8'he8, 8'h08);
      settle();
      acc(1'b1, 8'he8, 8'h28);
      settle();
      pm_u.sda_low = r;
      acc(1'b1, 8'he8, 8'h08);
      settle();
      acc(1'b0, 8'he8, 8'h00);
      check(rd[4], r);
    end
    pm_u.sda_low = 1'b0;
    check(8'(pm_u.stuck), 8'h00);
    final_report();
  end
endmodule : i2csl_top_tb
